// ---- core/arf_result_fifo.sv ----
// Result buffer and parallel host port of a multichannel converter.
// Assumes conversion words arrive on mclk with valid/ready, and that host
// pins are asynchronous to mclk and are held for several mclk periods.
// Functional notes
// R1: Sixteen-word circular result buffer.
// R2: Conversion words stored without host action.
// R3: Read pointer addresses next word delivered.
// R4: Write pointer addresses last stored word.
// R5: Autoscan order fixes channel per position.
// R6: Pulse when written count reaches trigger.
// R7: Host reads exactly trigger-level words per pulse.
// R8: Each block starts with first scan channel.
// R9: Programmable trigger; single input 1,4,8,14.
// R10: Data-available is an active-low pulse.
// R11: Read strobe combines both selects and read.
// R12: Two ten-bit configuration registers.
// R13: D0-D9 value, D10/D11 register address.
// R14: Host never writes with D11 high.
// R15: First register field layout.
// R16: Second register field layout.
// R17: Host follows configuration flow first.
// R18: Sleep still allows register and buffer access.
// R19: Test voltage mode suppresses data-available.
// R20: Pointers wrap modulo sixteen.
`timescale 1ns/1ns
`include "arf_params.svh"
module arf_result_fifo
  import arf_pkg::*;
#(
  parameter int DEPTH = `ARF_DEPTH
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Conversion result stream
  input wire logic conv_valid,
  input wire logic [`ARF_DATA_W-1:0] conv_data,
  output logic conv_ready,
  output logic [1:0] conv_chan,
  // Host pins
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [`ARF_DATA_W-1:0] data_in,
  output logic [`ARF_DATA_W-1:0] data_out,
  output logic data_oe,
  output logic block_ready_pulse_n,
  // Configuration seen by the converter core
  output arf_cfg0_type input_and_mode_config,
  output arf_cfg1_type buffer_and_output_config
);

  // ==========================================================================
  // Pin synchronisers
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic rd_prev_q;
  logic wr_prev_q;
  // R11 read strobe combine
  wire rd_act = ~pin_s2_q[15] & pin_s2_q[14] & ~pin_s2_q[13];
  wire wr_act = ~pin_s2_q[15] & pin_s2_q[14] & ~pin_s2_q[12];
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_s1_q <= `ARF_PIN_IDLE;
      pin_s2_q <= `ARF_PIN_IDLE;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {chip_select_low_n, chip_select_high, rd_n, wr_n, data_in};
      pin_s2_q <= pin_s1_q;
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  wire rd_start = rd_act & ~rd_prev_q;
  wire wr_start = wr_act & ~wr_prev_q;
  wire [`ARF_DATA_W-1:0] bus_word = pin_s2_q[`ARF_DATA_W-1:0];
  // R13 address from upper lines
  wire [1:0] reg_addr = bus_word[`ARF_DATA_W-1:`ARF_ADDR_LSB];
  wire [`ARF_CFG_W-1:0] reg_value = bus_word[`ARF_CFG_W-1:0];
  wire wr_cfg0 = wr_start & (reg_addr == `ARF_ADDR_CFG0);
  wire wr_cfg1 = wr_start & (reg_addr == `ARF_ADDR_CFG1);

  // ==========================================================================
  // Configuration registers
  arf_cfg0_type cfg0_q;
  arf_cfg1_type cfg1_q;
  // Clear and reset bits act once and never stay set
  wire soft_reset = wr_cfg1 & reg_value[`ARF_CFG1_RESET_BIT];
  wire flush = wr_cfg1 & (reg_value[`ARF_CFG1_CLEAR_BIT] | reg_value[`ARF_CFG1_RESET_BIT]);
  wire [`ARF_CFG_W-1:0] cfg1_wval = reg_value & ~`ARF_CFG_W'h003;

  // R12 two ten-bit registers
  // R15 R16 field layout
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg0_q <= `ARF_CFG0_RST;
      cfg1_q <= `ARF_CFG1_RST;
    end
    else if (soft_reset)
    begin
      cfg0_q <= `ARF_CFG0_RST;
      cfg1_q <= `ARF_CFG1_RST;
    end
    else
    begin
      if (wr_cfg0)
        cfg0_q <= reg_value;
      if (wr_cfg1)
        cfg1_q <= cfg1_wval;
    end
  end
  // R14 upper codes reserved
  // Writes with reg_addr[1] set match neither decode and are dropped.

  assign input_and_mode_config = cfg0_q;
  assign buffer_and_output_config = cfg1_q;

  // ==========================================================================
  // Scan order and trigger level
  wire [2:0] n_chan = cfg0_q.scan_enable ? ({1'b0, cfg0_q.input_pick} + 3'h1) : 3'h1;
  wire [1:0] trig = cfg1_q.fill_threshold_sel;
  wire [4:0] multi_lvl = 5'(n_chan) * (5'(trig) + 5'h01);
  // R9 selectable trigger level
  wire [4:0] one_lvl = (trig == 2'h0) ? `ARF_LVL_T0 :
                       (trig == 2'h1) ? `ARF_LVL_T1 :
                       (trig == 2'h2) ? `ARF_LVL_T2 : `ARF_LVL_T3;
  // Levels for several channels are whole scans so blocks stay aligned
  wire [4:0] trig_lvl = (n_chan == 3'h1) ? one_lvl :
                        (multi_lvl > 5'(DEPTH)) ? 5'(DEPTH) : multi_lvl;
  wire test_mode = cfg0_q.selftest_voltage_sel != 2'h0;

  // ==========================================================================
  // Two-entry skid buffer on the conversion stream
  logic [`ARF_DATA_W-1:0] sk_mem_q [2];
  logic sk_head_q;
  logic [1:0] sk_cnt_q;
  logic [1:0] chan_q;
  wire sk_in = conv_valid & conv_ready;
  wire sk_valid = sk_cnt_q != 2'h0;
  logic [`ARF_CNT_W-1:0] count_q;
  logic avail_n_q;
  // R2 automatic store
  // A store waits out the pulse cycle, so two pulses never merge into one
  // long low level; the skid buffer absorbs the one-cycle stall.
  wire push = sk_valid & (count_q < `ARF_CNT_W'(DEPTH)) & ~flush & avail_n_q;
  // Sleep stops new conversions only; host reads stay served
  assign conv_ready = (sk_cnt_q != 2'h2) & ~cfg0_q.sleep_enable;
  assign conv_chan = chan_q;

  always_ff @(posedge mclk)
  begin
    if (srst || flush)
    begin
      sk_head_q <= 1'b0;
      sk_cnt_q <= 2'h0;
      chan_q <= 2'h0;
    end
    else
    begin
      if (sk_in)
        sk_mem_q[sk_head_q ^ sk_cnt_q[0]] <= conv_data;
      if (push)
        sk_head_q <= ~sk_head_q;
      sk_cnt_q <= sk_cnt_q + {1'b0, sk_in} - {1'b0, push};
      // R5 fixed scan order
      // A new scan setup restarts at the first channel
      if (wr_cfg0)
        chan_q <= 2'h0;
      else if (sk_in)
        chan_q <= (3'({1'b0, chan_q}) + 3'h1 >= n_chan) ? 2'h0 : chan_q + 2'h1;
    end
  end

  // ==========================================================================
  // Circular buffer
  logic [`ARF_DATA_W-1:0] mem_q [DEPTH];
  logic [`ARF_PTR_W-1:0] last_ptr_q;
  logic [`ARF_PTR_W-1:0] rd_ptr_q;
  logic [`ARF_CNT_W-1:0] blk_cnt_q;
  logic [`ARF_DATA_W-1:0] data_out_q;
  // R18 reads not gated by sleep
  wire pop = rd_start & (count_q != `ARF_CNT_W'h0) & ~flush;
  wire [`ARF_PTR_W-1:0] wr_slot = last_ptr_q + `ARF_PTR_W'h1;
  wire [`ARF_DATA_W-1:0] head_word = mem_q[rd_ptr_q];
  // Two's complement differs from offset binary only in the sign bit
  wire [`ARF_DATA_W-1:0] fmt_word =
    {head_word[`ARF_DATA_W-1] ^ cfg1_q.output_code_format, head_word[`ARF_DATA_W-2:0]};
  wire blk_done = push & (blk_cnt_q + `ARF_CNT_W'h1 >= trig_lvl);

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wr_slot] <= sk_mem_q[sk_head_q];
  end

  always_ff @(posedge mclk)
  begin
    if (srst || flush)
    begin
      last_ptr_q <= `ARF_PTR_W'hF;
      rd_ptr_q <= `ARF_PTR_W'h0;
      count_q <= `ARF_CNT_W'h0;
      blk_cnt_q <= `ARF_CNT_W'h0;
      avail_n_q <= 1'b1;
    end
    else
    begin
      // R1 R20 capacity and wrap
      // R4 last written slot
      if (push)
        last_ptr_q <= wr_slot;
      // R3 next word to read
      if (pop)
        rd_ptr_q <= rd_ptr_q + `ARF_PTR_W'h1;
      count_q <= count_q + {4'h0, push} - {4'h0, pop};
      // R6 R8 block counting
      blk_cnt_q <= blk_done ? `ARF_CNT_W'h0 : blk_cnt_q + {4'h0, push};
      // R10 R19 low pulse
      avail_n_q <= ~(blk_done & ~test_mode);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      data_out_q <= `ARF_DATA_W'h000;
    else if (pop)
      data_out_q <= fmt_word;
  end

  // R7 host reads one block
  // The host owns the block size; extra reads on an empty buffer keep old data.
  assign data_out = data_out_q;
  assign data_oe = rd_act;
  assign block_ready_pulse_n = avail_n_q;

  // ==========================================================================
  // Checks
  sequence s_low_pulse;
    !block_ready_pulse_n ##1 block_ready_pulse_n;
  endsequence

  property p_cap;
    @(posedge mclk) disable iff (srst) count_q <= `ARF_CNT_W'(DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("buffer count above depth"); // R1

  property p_auto_store;
    @(posedge mclk) disable iff (srst)
      push && !pop |=> count_q == $past(count_q) + `ARF_CNT_W'h01;
  endproperty
  a_auto_store: assert property (p_auto_store) else $error("stored word not counted"); // R2

  property p_wptr;
    @(posedge mclk) disable iff (srst) push && !flush |=> last_ptr_q == $past(wr_slot);
  endproperty
  a_wptr: assert property (p_wptr) else $error("write pointer not advanced"); // R4 R20

  property p_rptr;
    @(posedge mclk) disable iff (srst)
      pop |=> rd_ptr_q == $past(rd_ptr_q) + `ARF_PTR_W'h1;
  endproperty
  a_rptr: assert property (p_rptr) else $error("read pointer not advanced"); // R3

  property p_pulse_cause;
    @(posedge mclk) disable iff (srst) $fell(block_ready_pulse_n) |-> $past(push);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without store"); // R6

  property p_pulse_shape;
    @(posedge mclk) disable iff (srst) !block_ready_pulse_n |-> s_low_pulse;
  endproperty
  a_pulse_shape: assert property (p_pulse_shape) else $error("pulse longer than one cycle"); // R10

  property p_test_quiet;
    @(posedge mclk) disable iff (srst) $past(test_mode) |-> block_ready_pulse_n;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("pulse in test mode"); // R19

  property p_cfg0_write;
    @(posedge mclk) disable iff (srst) wr_cfg0 |=> cfg0_q == $past(reg_value);
  endproperty
  a_cfg0_write: assert property (p_cfg0_write) else $error("register 0 not written"); // R13

  property p_reserved;
    @(posedge mclk) disable iff (srst)
      wr_start && reg_addr[1] |=> $stable(cfg0_q) && $stable(cfg1_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved address changed a register"); // R14

  property p_scan_range;
    @(posedge mclk) disable iff (srst) 3'({1'b0, chan_q}) < n_chan || $past(wr_cfg0);
  endproperty
  a_scan_range: assert property (p_scan_range) else $error("scan channel out of range"); // R5

endmodule : arf_result_fifo

// ---- core/arf_params.svh ----
// Constants of the result buffer and host port: addresses, reset values,
// field positions and trigger levels. Included by the package and the core.
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH
`define ARF_DEPTH 16
`define ARF_CNT_W 5
`define ARF_PTR_W 4
`define ARF_DATA_W 12
`define ARF_CFG_W 10
`define ARF_ADDR_LSB 10
`define ARF_ADDR_CFG0 2'h0
`define ARF_ADDR_CFG1 2'h1
`define ARF_CFG0_RST 10'h020
`define ARF_CFG1_RST 10'h000
`define ARF_CFG1_CLEAR_BIT 1
`define ARF_CFG1_RESET_BIT 0
`define ARF_LVL_T0 5'h01
`define ARF_LVL_T1 5'h04
`define ARF_LVL_T2 5'h08
`define ARF_LVL_T3 5'h0E
`define ARF_PIN_IDLE 16'hB000
`endif

// ---- core/arf_pkg.sv ----
// Types of the result buffer: the two configuration register layouts.
// Assumes arf_params.svh sits in the include path.
`include "arf_params.svh"
package arf_pkg;
  typedef struct packed {
    logic [1:0] selftest_voltage_sel;
    logic scan_enable;
    logic [1:0] balanced_input_count;
    logic [1:0] input_pick;
    logic sleep_enable;
    logic conv_mode;
    logic ref_select;
  } arf_cfg0_type;

  typedef struct packed {
    logic config_readback_enable;
    logic offset_enable;
    logic output_code_format;
    logic read_write_sel;
    logic ready_polarity;
    logic ready_type;
    logic [1:0] fill_threshold_sel;
    logic overflow_or_buffer_clear;
    logic soft_reset;
  } arf_cfg1_type;
endpackage : arf_pkg

// ---- verification/arf_conv_source.sv ----
// Conversion word source standing in for the converter core.
// Assumes one clock; the bench asks for a number of words by a strobe.
`timescale 1ns/1ns
module arf_conv_source
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bench request
  input wire logic req_stb,
  input wire logic [4:0] req_cnt,
  // Stream into the buffer
  input wire logic conv_ready,
  input wire logic [1:0] conv_chan,
  output logic conv_valid,
  output logic [11:0] conv_data
);
  logic [4:0] left_q;
  logic [9:0] seq_q;
  logic [11:0] word;
  // Channel in the top bits lets the bench see the scan order
  assign word = {conv_chan, seq_q};
  assign conv_valid = (left_q != 5'h00);
  // Idle lines show the inverse, so a stale word never passes for data
  assign conv_data = conv_valid ? word : ~word;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      left_q <= 5'h00;
      seq_q <= 10'h000;
    end
    else if (req_stb)
      left_q <= req_cnt;
    else if (conv_valid && conv_ready)
    begin
      left_q <= left_q - 5'h01;
      seq_q <= seq_q + 10'h001;
    end
  end
endmodule : arf_conv_source

// ---- verification/adc_result_fifo_host_port_tb_top.sv ----
// Bench for the result buffer: host pin tasks and a word source.
// Assumes the core and package files are compiled before this one.
`timescale 1ns/1ns
module adc_result_fifo_host_port_tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cs_n = 1'b1, cs_h = 1'b0, rd_n = 1'b1, wr_n = 1'b1, req_stb = 1'b0;
  logic [11:0] din = 12'h000;
  logic [11:0] dout, conv_data;
  logic conv_valid, conv_ready, oe, pulse_n;
  logic [1:0] chan;
  logic [4:0] req_cnt = 5'h00;
  logic [9:0] cfg0, cfg1;
  logic [9:0] seq = 10'h000;
  logic [4:0] lvl_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int n_errors = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  arf_result_fifo u_arf_result_fifo (.mclk(mclk), .srst(srst), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .conv_chan(chan),
    .chip_select_low_n(cs_n), .chip_select_high(cs_h), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .block_ready_pulse_n(pulse_n),
    .input_and_mode_config(cfg0), .buffer_and_output_config(cfg1));
  arf_conv_source u_arf_conv_source (.mclk(mclk), .srst(srst), .req_stb(req_stb),
    .req_cnt(req_cnt), .conv_ready(conv_ready), .conv_chan(chan),
    .conv_valid(conv_valid), .conv_data(conv_data));
  // ==========================================
  // Shared tasks
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Data settles four cycles before the strobe, as the pin sync needs
  task automatic host_wr(input logic [1:0] a, input logic [9:0] v);
    din = {a, v};
    cyc(4);
    cs_n = 1'b0;
    cs_h = 1'b1;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cs_n = 1'b1;
    cs_h = 1'b0;
    cyc(4);
  endtask : host_wr
  task automatic host_rd(output logic [11:0] v);
    cs_n = 1'b0;
    cs_h = 1'b1;
    rd_n = 1'b0;
    cyc(6);
    v = dout;
    check({11'h000, oe}, 12'h001);
    rd_n = 1'b1;
    cs_n = 1'b1;
    cs_h = 1'b0;
    cyc(4);
  endtask : host_rd
  task automatic send(input logic [4:0] n);
    req_cnt = n;
    req_stb = 1'b1;
    cyc(1);
    req_stb = 1'b0;
  endtask : send
  task automatic wait_pulse(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 200 && !seen; i++)
    begin
      @(posedge mclk);
      #1;
      if (pulse_n === 1'b0)
        seen = 1'b1;
    end
    @(negedge mclk);
  endtask : wait_pulse
  task automatic rd_chk(input int nch, input int n);
    logic [11:0] v;
    for (int i = 0; i < n; i++)
    begin
      host_rd(v);
      check(v, {2'(i % nch), seq});
      seq++;
    end
  endtask : rd_chk
  // Flush, set the level, push one block and read it back (host reads exactly lvl)
  task automatic block(input logic [1:0] trig, input logic [4:0] lvl, input int nch);
    logic seen;
    host_wr(2'h1, {6'h00, trig, 2'h2});
    check({2'h0, cfg1}, {8'h00, trig, 2'h0});
    send(lvl);
    wait_pulse(seen);
    check({11'h000, seen}, 12'h001);
    if (!seen)
      final_report();
    rd_chk(nch, int'(lvl));
  endtask : block
  // ==========================================
  // Main sequence
  initial
  begin
    logic [11:0] v;
    logic seen;
    cyc(10);
    srst = 1'b0;
    cyc(3);
    check({2'h0, cfg0}, 12'h020);
    check({2'h0, cfg1}, 12'h000);
    check({11'h000, pulse_n}, 12'h001);
    for (int k = 0; k < 4; k++)
      block(2'(k), lvl_tab[k], 1);
    $display("trigger levels done");
    host_wr(2'h1, 10'h00E);
    send(5'h12);
    cyc(40);
    check({11'h000, conv_ready}, 12'h000);
    rd_chk(1, 18);
    host_rd(v);
    check(v, {2'h0, seq - 10'h001});
    $display("fill and drain done");
    host_wr(2'h0, 10'h0A8);
    check({2'h0, cfg0}, 12'h0A8);
    block(2'h1, 5'h04, 2);
    for (int a = 2; a < 4; a++)
      host_wr(2'(a), 10'h3FF);
    check({2'h0, cfg0}, 12'h0A8);
    $display("autoscan and addressing done");
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(6);
    check({11'h000, oe}, 12'h000);
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(4);
    host_wr(2'h0, 10'h1A8);
    host_wr(2'h1, 10'h002);
    send(5'h02);
    wait_pulse(seen);
    check({11'h000, seen}, 12'h000);
    rd_chk(2, 2);
    $display("select and selftest done");
    host_wr(2'h1, 10'h001);
    check({2'h0, cfg0}, 12'h020);
    check({2'h0, cfg1}, 12'h000);
    host_wr(2'h1, 10'h082);
    check({2'h0, cfg1}, 12'h080);
    send(5'h01);
    wait_pulse(seen);
    check({11'h000, seen}, 12'h001);
    host_wr(2'h0, 10'h024);
    check({2'h0, cfg0}, 12'h024);
    check({11'h000, conv_ready}, 12'h000);
    host_rd(v);
    check(v, {2'h2, seq});
    seq++;
    $display("sleep and code format done");
    final_report();
  end
endmodule : adc_result_fifo_host_port_tb_top
